/* File: rtl/pss_map.svh */
// register offsets, field positions, reset values and timing for the supply supervisor
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH

// register byte offsets
`define PSS_OFF_CTRL        8'h00
`define PSS_OFF_MASK        8'h04
`define PSS_OFF_DISCH       8'h08
`define PSS_OFF_POR         8'h0C
`define PSS_OFF_SEQ         8'h10
`define PSS_OFF_STATUS      8'h14

// control register fields
`define PSS_CTRL_NORMAL     0
`define PSS_CTRL_TRIG_RISE  1

// discharge register fields
`define PSS_DISCH_SEL_LSB   0
`define PSS_DISCH_SINK_LSB  8

// reset threshold and delay register fields
`define PSS_POR_DLY_LSB     0
`define PSS_POR_RISE_LSB    8
`define PSS_POR_FALL_LSB    16

// status register fields
`define PSS_ST_CE           0
`define PSS_ST_LOCK_OK      1
`define PSS_ST_POR          2
`define PSS_ST_GOOD         3
`define PSS_ST_SEQ_DONE     4
`define PSS_ST_NORMAL       5
`define PSS_ST_REG_EN_LSB   8

// reset values
`define PSS_RST_MASK        6'h00
`define PSS_RST_DISCH       6'h3F
`define PSS_RST_SINK        2'h3
`define PSS_RST_POR_DLY     5'h00
`define PSS_RST_RISE_THR    6'h14
`define PSS_RST_FALL_THR    6'h10
`define PSS_RST_SEQ_DLY     3'h0

// timing
`define PSS_CLK_PERIOD_NS   10
`define PSS_TICK_NS         1000
`define PSS_DEGLITCH_US     50
`define PSS_POR_STEP_US     5000
`define PSS_SEQ_STEP_US     1000

// positions inside the asynchronous input vector
`define PSS_AI_LP           0
`define PSS_AI_CE           1
`define PSS_AI_THERM        2
`define PSS_AI_POR_HI       3
`define PSS_AI_POR_LO       4
`define PSS_AI_LOCK_HI      5
`define PSS_AI_LOCK_LO      6
`define PSS_AI_GOOD_LSB     7
`define PSS_AI_RAMP_LSB     13
`define PSS_AI_W            19

`endif

/* File: rtl/pss_pkg.sv */
// types of the supply supervisor
`include "pss_map.svh"

package pss_pkg;

  typedef enum logic [1:0] {
    SEQ_OFF,
    SEQ_RUN,
    SEQ_ON
  } pss_seq_t;

  typedef struct packed {
    logic [`PSS_AI_W-1:0] sync1;
    logic [`PSS_AI_W-1:0] sync2;
    logic                 lpPrev;
    logic                 runPrev;
    logic                 normal;
    logic                 trigRise;
    logic [5:0]           mask;
    logic [5:0]           dischSel;
    logic [1:0]           sinkCode;
    logic [4:0]           porDly;
    logic [5:0]           riseThr;
    logic [5:0]           fallThr;
    logic [2:0]           seqDly;
    logic [6:0]           tickCnt;
    logic                 tick;
    logic                 lockOk;
    logic                 porArm;
    logic                 supply_rise_threshold;
    logic [17:0]          porCnt;
    pss_seq_t             seq;
    logic [2:0]           seqSlot;
    logic [17:0]          seqCnt;
    logic [5:0]           regEn;
    logic                 disconnectOn;
    logic [5:0]           dischargeEn;
    logic [5:0]           glitchCnt;
    logic                 globalGood;
    logic                 loadDefaults;
    logic                 pready;
    logic [31:0]          prdata;
    logic                 pslverr;
  } pss_state_t;

endpackage : pss_pkg

/* File: rtl/pss_state_supervisor.sv */
// supervisory control of a multi-output power device: standby, reset output, power good, enable
//
// Operation
// - in normal mode, default falling edge on request pin enters standby.
// - entering standby through the pin clears the normal flag to zero.
// - opposite pin edge or write of the normal flag restores normal defaults.
// - standby trigger polarity selectable, falling by default, rising alternative.
// - reset delay counts after supply passes rise threshold; release only after it.
// - reset output drops at once when supply falls under fall threshold.
// - global good high only when every output is good or masked.
// - any unmasked output bad or thermal fault pulls global good low.
// - falling good condition is deglitched; drops shorter than interval ignored.
// - masked output fault never de-asserts global good.
// - six mask bits, one per output; one means masked.
// - rising chip enable starts the programmed output start-up sequence.
// - chip enable low turns all outputs off and opens the boost disconnect.
// - no register programming accepted while chip enable is low.
// - disabled output discharges only when its pull-down select bit is set.
// - start-up after lockout rise threshold; outputs stay on until fall threshold.
// - bus interface samples and drives on rising clock edges, answering in the first access cycle.
// - masked output's good indication is blanked while it ramps.
`timescale 1ns/1ps

module pss_state_supervisor
  import pss_pkg::*;
#(
  parameter int POR_STEP_US = `PSS_POR_STEP_US,
  parameter int SEQ_STEP_US = `PSS_SEQ_STEP_US
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lowPowerRequestPin,
  input  wire logic        chipEnablePin,
  input  wire logic        thermalFault,
  input  wire logic        supplyAboveRise,
  input  wire logic        supplyBelowFall,
  input  wire logic        lockoutAboveRise,
  input  wire logic        lockoutBelowFall,
  input  wire logic [5:0]  outputGood,
  input  wire logic [5:0]  outputRamping,
  output logic             porOut,
  output logic             globalGoodOut,
  output logic             normalStateFlag,
  output logic             loadNormalDefaults,
  output logic [5:0]       regulatorEnable,
  output logic [4:0]       bucketDischargeEn,
  output logic             boostSinkEn,
  output logic [1:0]       boostSinkCode,
  output logic             boostDisconnectOut,
  output logic [5:0]       supplyRiseThreshold,
  output logic [5:0]       supplyFallThreshold
);

  localparam int TICK_CYCLES = `PSS_TICK_NS / `PSS_CLK_PERIOD_NS;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);
  localparam logic [5:0] DEGL_LAST = 6'(`PSS_DEGLITCH_US - 1);

  // a step count times a step length in microsecond ticks
  function automatic logic [17:0] stepTarget(input logic [5:0] steps, input int stepUs);
    stepTarget = 18'(int'(steps) * stepUs);
  endfunction : stepTarget

  pss_state_t s;
  pss_state_t n;

  logic [`PSS_AI_W-1:0] asyncIn;

  assign asyncIn = {outputRamping, outputGood, lockoutBelowFall, lockoutAboveRise,
                    supplyBelowFall, supplyAboveRise, thermalFault, chipEnablePin,
                    lowPowerRequestPin};

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic       lp;
    logic       ce;
    logic       therm;
    logic [5:0] good;
    logic [5:0] ramp;
    logic [5:0] okVec;
    logic       run;
    logic       lpRise;
    logic       lpFall;
    logic       enterEdge;
    logic       exitEdge;
    logic       setup;
    logic       wrDone;
    logic [17:0] porTarget;
    logic [17:0] seqTarget;
    lp        = 1'b0;
    ce        = 1'b0;
    therm     = 1'b0;
    good      = 6'h00;
    ramp      = 6'h00;
    okVec     = 6'h00;
    run       = 1'b0;
    lpRise    = 1'b0;
    lpFall    = 1'b0;
    enterEdge = 1'b0;
    exitEdge  = 1'b0;
    setup     = 1'b0;
    wrDone    = 1'b0;
    porTarget = 18'h00000;
    seqTarget = 18'h00000;

    n = s;
    n.tick         = 1'b0;
    n.loadDefaults = 1'b0;

    n.sync1 = asyncIn;
    n.sync2 = s.sync1;
    lp    = s.sync2[`PSS_AI_LP];
    ce    = s.sync2[`PSS_AI_CE];
    therm = s.sync2[`PSS_AI_THERM];
    good  = s.sync2[`PSS_AI_GOOD_LSB +: 6];
    ramp  = s.sync2[`PSS_AI_RAMP_LSB +: 6];

    // microsecond enable pulse
    if (s.tickCnt == TICK_LAST) begin
      n.tickCnt = 7'h00;
      n.tick    = 1'b1;
    end else begin
      n.tickCnt = s.tickCnt + 7'h01;
    end

    if (s.sync2[`PSS_AI_LOCK_LO]) begin
      n.lockOk = 1'b0;
    end else if (s.sync2[`PSS_AI_LOCK_HI]) begin
      n.lockOk = 1'b1;
    end
    run       = ce & s.lockOk;
    n.runPrev = run;

    // reset output falls with no delay count
    porTarget = stepTarget(6'({1'b0, s.porDly} + 6'h01), POR_STEP_US);
    if (s.sync2[`PSS_AI_POR_LO]) begin
      n.porArm = 1'b0;
      n.supply_rise_threshold  = 1'b0;
      n.porCnt = 18'h00000;
    end else begin
      if (s.sync2[`PSS_AI_POR_HI]) begin
        n.porArm = 1'b1;
      end
      // release only after the full delay
      if (s.porArm && !s.supply_rise_threshold && s.tick) begin
        if (s.porCnt >= porTarget - 18'h00001) begin
          n.supply_rise_threshold = 1'b1;
        end else begin
          n.porCnt = s.porCnt + 18'h00001;
        end
      end
    end

    // output start-up sequence, one output per slot
    seqTarget = stepTarget({3'h0, s.seqDly}, SEQ_STEP_US);
    case (s.seq)
      SEQ_OFF: begin
        if (run && !s.runPrev) begin
          n.seq     = SEQ_RUN;
          n.seqSlot = 3'h0;
          n.seqCnt  = 18'h00000;
        end
      end
      SEQ_RUN: begin
        if (s.seqCnt >= seqTarget) begin
          n.regEn[s.seqSlot] = 1'b1;
          n.seqCnt           = 18'h00000;
          if (s.seqSlot == 3'h5) begin
            n.seq = SEQ_ON;
          end else begin
            n.seqSlot = s.seqSlot + 3'h1;
          end
        end else if (s.tick) begin
          n.seqCnt = s.seqCnt + 18'h00001;
        end
      end
      SEQ_ON: begin
        n.seq = SEQ_ON;
      end
      default: begin
        n.seq = SEQ_OFF;
      end
    endcase

    // enable low drops every output at once
    if (!run) begin
      n.seq     = SEQ_OFF;
      n.regEn   = 6'h00;
      n.seqSlot = 3'h0;
      n.seqCnt  = 18'h00000;
    end
    // disconnect open unless boost is on
    n.disconnectOn = run & n.regEn[5];
    n.dischargeEn  = ~n.regEn & s.dischSel;

    okVec = good | s.mask | (s.mask & ramp);
    if ((&okVec) && !therm) begin
      n.globalGood = 1'b1;
      n.glitchCnt  = 6'h00;
    end else if (s.tick) begin
      if (s.glitchCnt == DEGL_LAST) begin
        n.globalGood = 1'b0;
      end else begin
        n.glitchCnt = s.glitchCnt + 6'h01;
      end
    end

    lpRise    = lp & ~s.lpPrev;
    lpFall    = ~lp & s.lpPrev;
    n.lpPrev  = lp;
    enterEdge = s.trigRise ? lpRise : lpFall;
    exitEdge  = s.trigRise ? lpFall : lpRise;
    if (s.normal && enterEdge) begin
      n.normal = 1'b0;
    end else if (!s.normal && exitEdge) begin
      n.normal       = 1'b1;
      n.loadDefaults = 1'b1;
    end

    // rising-edge sampling; answer registered in setup, used in access
    setup  = psel & ~penable;
    wrDone = psel & penable & s.pready & pwrite;
    n.pready = setup;
    if (setup) begin
      n.prdata  = 32'h00000000;
      n.pslverr = 1'b0;
      case (paddr)
        `PSS_OFF_CTRL: begin
          n.prdata[`PSS_CTRL_NORMAL]    = s.normal;
          n.prdata[`PSS_CTRL_TRIG_RISE] = s.trigRise;
        end
        `PSS_OFF_MASK: n.prdata[5:0] = s.mask;
        `PSS_OFF_DISCH: begin
          n.prdata[`PSS_DISCH_SEL_LSB +: 6]  = s.dischSel;
          n.prdata[`PSS_DISCH_SINK_LSB +: 2] = s.sinkCode;
        end
        `PSS_OFF_POR: begin
          n.prdata[`PSS_POR_DLY_LSB +: 5]  = s.porDly;
          n.prdata[`PSS_POR_RISE_LSB +: 6] = s.riseThr;
          n.prdata[`PSS_POR_FALL_LSB +: 6] = s.fallThr;
        end
        `PSS_OFF_SEQ: n.prdata[2:0] = s.seqDly;
        `PSS_OFF_STATUS: begin
          n.prdata[`PSS_ST_CE]               = ce;
          n.prdata[`PSS_ST_LOCK_OK]          = s.lockOk;
          n.prdata[`PSS_ST_POR]              = s.supply_rise_threshold;
          n.prdata[`PSS_ST_GOOD]             = s.globalGood;
          n.prdata[`PSS_ST_SEQ_DONE]         = (s.seq == SEQ_ON);
          n.prdata[`PSS_ST_NORMAL]           = s.normal;
          n.prdata[`PSS_ST_REG_EN_LSB +: 6]  = s.regEn;
        end
        default: n.pslverr = 1'b1;
      endcase
      // writes refused while enable is low
      if (pwrite && !ce) begin
        n.pslverr = 1'b1;
      end
    end else if (psel && penable && s.pready) begin
      n.prdata  = 32'h00000000;
      n.pslverr = 1'b0;
    end

    // write lands only with enable high
    if (wrDone && !s.pslverr) begin
      case (paddr)
        `PSS_OFF_CTRL: begin
          // bus write overrides a pin edge of the same cycle
          n.normal       = pwdata[`PSS_CTRL_NORMAL];
          // write of the flag restores defaults
          n.loadDefaults = pwdata[`PSS_CTRL_NORMAL];
          n.trigRise     = pwdata[`PSS_CTRL_TRIG_RISE];
        end
        `PSS_OFF_MASK: n.mask = pwdata[5:0];
        `PSS_OFF_DISCH: begin
          n.dischSel = pwdata[`PSS_DISCH_SEL_LSB +: 6];
          n.sinkCode = pwdata[`PSS_DISCH_SINK_LSB +: 2];
        end
        `PSS_OFF_POR: begin
          n.porDly  = pwdata[`PSS_POR_DLY_LSB +: 5];
          n.riseThr = pwdata[`PSS_POR_RISE_LSB +: 6];
          n.fallThr = pwdata[`PSS_POR_FALL_LSB +: 6];
        end
        `PSS_OFF_SEQ: n.seqDly = pwdata[2:0];
        default: n.seqDly = s.seqDly;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s              <= '0;
      s.normal       <= 1'b1;
      s.mask         <= `PSS_RST_MASK;
      s.dischSel     <= `PSS_RST_DISCH;
      s.sinkCode     <= `PSS_RST_SINK;
      s.porDly       <= `PSS_RST_POR_DLY;
      s.riseThr      <= `PSS_RST_RISE_THR;
      s.fallThr      <= `PSS_RST_FALL_THR;
      s.seqDly       <= `PSS_RST_SEQ_DLY;
      s.seq          <= SEQ_OFF;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, each a field of the state register

  assign prdata              = s.prdata;
  assign pready              = s.pready;
  assign pslverr             = s.pslverr;
  assign porOut              = s.supply_rise_threshold;
  assign globalGoodOut       = s.globalGood;
  assign normalStateFlag     = s.normal;
  assign loadNormalDefaults  = s.loadDefaults;
  assign regulatorEnable     = s.regEn;
  assign bucketDischargeEn   = s.dischargeEn[4:0];
  assign boostSinkEn         = s.dischargeEn[5];
  assign boostSinkCode       = s.sinkCode;
  assign boostDisconnectOut  = s.disconnectOn;
  assign supplyRiseThreshold = s.riseThr;
  assign supplyFallThreshold = s.fallThr;

endmodule : pss_state_supervisor

/* File: tb/pss_checker_asserts.sv */
// port-level assertions of the state supervisor
`timescale 1ns/1ps
module pss_checker #(
  parameter int POR_STEP_US = 5000
) (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       chipEnablePin,
  input wire logic       thermalFault,
  input wire logic       supplyAboveRise,
  input wire logic       supplyBelowFall,
  input wire logic [5:0] outputGood,
  input wire logic       porOut,
  input wire logic       globalGoodOut,
  input wire logic       normalStateFlag,
  input wire logic       loadNormalDefaults,
  input wire logic [5:0] regulatorEnable,
  input wire logic       boostDisconnectOut
);
  // tick granularity may cost up to one microsecond of the nominal count
  localparam int PorMin    = (POR_STEP_US - 1) * 100;
  localparam int GlitchMin = 4900;
  // wide enough for the full reset delay at the default step length
  logic [31:0] riseCnt_q;
  logic [31:0] badCnt_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      riseCnt_q <= 32'h0;
      badCnt_q  <= 32'h0;
    end else begin
      riseCnt_q <= supplyAboveRise ? riseCnt_q + 32'h1 : 32'h0;
      badCnt_q  <= (thermalFault || !(&outputGood)) ? badCnt_q + 32'h1 : 32'h0;
    end
  end
  ////////////////////////////////////////
  property p_exitPulse;
    $rose(normalStateFlag) |-> loadNormalDefaults;
  endproperty
  a_exitPulse: assert property (p_exitPulse) else $error("normal flag rose without defaults pulse");
  property p_pulseOne;
    loadNormalDefaults |=> !loadNormalDefaults;
  endproperty
  a_pulseOne: assert property (p_pulseOne) else $error("defaults pulse longer than one cycle");
  property p_porDrop;
    $rose(supplyBelowFall) |-> ##[1:4] !porOut;
  endproperty
  a_porDrop: assert property (p_porDrop) else $error("reset output late after supply drop");
  property p_porDelay;
    $rose(porOut) |-> riseCnt_q >= PorMin;
  endproperty
  a_porDelay: assert property (p_porDelay) else $error("reset output released too early");
  property p_thermalBlocks;
    $rose(globalGoodOut) |-> !$past(thermalFault, 3);
  endproperty
  a_thermalBlocks: assert property (p_thermalBlocks) else $error("good rose during thermal fault");
  property p_deglitch;
    $fell(globalGoodOut) |-> badCnt_q >= GlitchMin;
  endproperty
  a_deglitch: assert property (p_deglitch) else $error("good fell before deglitch interval");
  property p_ceOff;
    $fell(chipEnablePin) |-> ##[1:5] (regulatorEnable == 6'h00 && !boostDisconnectOut);
  endproperty
  a_ceOff: assert property (p_ceOff) else $error("outputs not off after enable low");
  property p_ceRefuse;
    (!chipEnablePin)[*5] ##0 (psel && penable && pready && pwrite) |-> pslverr;
  endproperty
  a_ceRefuse: assert property (p_ceRefuse) else $error("write accepted with enable low");
  property p_zeroWait;
    (psel && !penable) |=> (pready && penable);
  endproperty
  a_zeroWait: assert property (p_zeroWait) else $error("bus answer not in first access cycle");
endmodule : pss_checker

bind pss_state_supervisor pss_checker #(.POR_STEP_US(POR_STEP_US)) u_pss_checker (
  .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .chipEnablePin(chipEnablePin), .thermalFault(thermalFault),
  .supplyAboveRise(supplyAboveRise), .supplyBelowFall(supplyBelowFall), .outputGood(outputGood),
  .porOut(porOut), .globalGoodOut(globalGoodOut), .normalStateFlag(normalStateFlag),
  .loadNormalDefaults(loadNormalDefaults), .regulatorEnable(regulatorEnable),
  .boostDisconnectOut(boostDisconnectOut)
);

/* File: tb/pss_load_model.sv */
// behavioural loads: per-output good flags follow their enables
`timescale 1ns/1ps
module pss_load_model (
  input  wire logic       mclk,
  input  wire logic [5:0] regulatorEnable,
  input  wire logic [5:0] faultInject,
  output logic      [5:0] outputGood,
  output logic      [5:0] outputRamping
);
  logic [5:0] stage1_q;
  logic [5:0] stage2_q;
  // two-cycle ramp; a commanded fault drops the flag at once
  always_ff @(posedge mclk) begin
    stage1_q <= regulatorEnable;
    stage2_q <= stage1_q & regulatorEnable;
  end
  assign outputGood    = stage2_q & regulatorEnable & ~faultInject;
  assign outputRamping = regulatorEnable & ~stage2_q;
endmodule : pss_load_model

/* File: tb/pss_state_supervisor_test.sv */
// self-checking bench of the state supervisor
`timescale 1ns/1ps
module pss_state_supervisor_test;
  localparam logic [31:0] fullMask = 32'hFFFFFFFF;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata;
  logic        pready, pslverr, rerr;
  // pins sit at defined levels from time zero
  logic        lpPin = 1'b1;
  logic        cePin = 1'b0;
  logic        therm = 1'b0;
  logic        supRise = 1'b0;
  logic        supFall = 1'b1;
  logic        lockRise = 1'b1;
  logic        lockFall = 1'b0;
  logic [5:0]  riseThr, fallThr;
  logic [1:0]  sinkCode;
  logic [5:0]  fault = 6'h00;
  logic [5:0]  good, ramp, regEn;
  logic [4:0]  dischEn;
  logic        porOut, globalGood, normal, loadDef, sinkEn, discon;
  int          miscompares = 0;
  int          checksDone = 0;
  int          cycles = 0;
  int          n;

  always #5 mclk = ~mclk;

  pss_state_supervisor #(.POR_STEP_US(5), .SEQ_STEP_US(2)) u_pss_state_supervisor (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lowPowerRequestPin(lpPin),
    .chipEnablePin(cePin), .thermalFault(therm), .supplyAboveRise(supRise), .supplyBelowFall(supFall),
    .lockoutAboveRise(lockRise), .lockoutBelowFall(lockFall), .outputGood(good), .outputRamping(ramp),
    .porOut(porOut), .globalGoodOut(globalGood), .normalStateFlag(normal), .loadNormalDefaults(loadDef),
    .regulatorEnable(regEn), .bucketDischargeEn(dischEn), .boostSinkEn(sinkEn), .boostSinkCode(sinkCode),
    .boostDisconnectOut(discon), .supplyRiseThreshold(riseThr), .supplyFallThreshold(fallThr));
  pss_load_model u_pss_load_model (.mclk(mclk), .regulatorEnable(regEn), .faultInject(fault),
    .outputGood(good), .outputRamping(ramp));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // changed just after rising edges, held until the edge that samples pready high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [31:0] exp, input logic err);
    int   k;
    logic rdy;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdata = prdata;
    rerr = pslverr;
    rdy = pready;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 1'b1, rdy);
    chk("pslverr", err, rerr);
    chk("prdata", exp, rdata & m);
  endtask : bus

  task automatic pin(input logic v, input logic expNormal, input logic expDef);
    @(posedge mclk);
    lpPin <= v;
    repeat (4) @(negedge mclk);
    chk("normalStateFlag", expNormal, normal);
    chk("loadNormalDefaults", expDef, loadDef);
  endtask : pin

  task automatic summarize();
    if (miscompares == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      summarize();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    chk("supplyRiseThreshold", 32'h14, riseThr);
    chk("supplyFallThreshold", 32'h10, fallThr);
    chk("boostSinkCode", 32'h3, sinkCode);
    bus(1'h0, 8'h00, 32'h0, fullMask, 32'h1, 1'h0);
    bus(1'h0, 8'h04, 32'h0, fullMask, 32'h0, 1'h0);
    bus(1'h0, 8'h08, 32'h0, fullMask, 32'h33F, 1'h0);
    bus(1'h0, 8'h0C, 32'h0, fullMask, 32'h101400, 1'h0);
    bus(1'h0, 8'h18, 32'h0, fullMask, 32'h0, 1'h1);
    bus(1'h1, 8'h04, 32'h3F, 32'h0, 32'h0, 1'h1);
    bus(1'h0, 8'h04, 32'h0, fullMask, 32'h0, 1'h0);
    @(posedge mclk);
    cePin <= 1'b1;
    for (n = 0; n < 40 && regEn === 6'h00; n++) @(negedge mclk);
    for (n = 0; n < 6; n++) begin
      chk("regulatorEnable", (32'h1 << (n + 1)) - 32'h1, regEn);
      @(negedge mclk);
    end
    chk("boostDisconnectOut", 1'b1, discon);
    chk("bucketDischargeEn", 5'h00, dischEn);
    bus(1'h0, 8'h14, 32'h0, 32'h3F33, 32'h3F33, 1'h0);
    @(posedge mclk);
    lockRise <= 1'b0;
    lockFall <= 1'b1;
    repeat (5) @(negedge mclk);
    chk("regulatorEnable", 32'h0, regEn);
    @(posedge mclk);
    lockFall <= 1'b0;
    repeat (5) @(negedge mclk);
    chk("regulatorEnable", 32'h0, regEn);
    @(posedge mclk);
    lockRise <= 1'b1;
    repeat (12) @(negedge mclk);
    chk("regulatorEnable", 32'h3F, regEn);
    @(posedge mclk);
    supFall <= 1'b0;
    supRise <= 1'b1;
    for (n = 0; n < 2000 && porOut !== 1'b1; n++) @(negedge mclk);
    chk("porDelay", 1'b1, n >= 400 && n <= 520);
    @(posedge mclk);
    supFall <= 1'b1;
    supRise <= 1'b0;
    repeat (4) @(negedge mclk);
    chk("porOut", 1'b0, porOut);
    pin(1'b0, 1'b0, 1'b0);
    pin(1'b1, 1'b1, 1'b1);
    bus(1'h1, 8'h00, 32'h0, 32'h0, 32'h0, 1'h0);
    @(negedge mclk);
    chk("normalStateFlag", 1'b0, normal);
    bus(1'h1, 8'h00, 32'h1, 32'h0, 32'h0, 1'h0);
    @(negedge mclk);
    chk("loadNormalDefaults", 1'b1, loadDef);
    bus(1'h1, 8'h00, 32'h3, 32'h0, 32'h0, 1'h0);
    @(negedge mclk);
    pin(1'b0, 1'b1, 1'b0);
    pin(1'b1, 1'b0, 1'b0);
    pin(1'b0, 1'b1, 1'b1);
    bus(1'h1, 8'h00, 32'h1, 32'h0, 32'h0, 1'h0);
    for (n = 0; n < 40 && globalGood !== 1'b1; n++) @(negedge mclk);
    chk("globalGoodOut", 1'b1, globalGood);
    @(posedge mclk);
    fault <= 6'h04;
    repeat (2000) @(posedge mclk);
    fault <= 6'h00;
    repeat (10) @(negedge mclk);
    chk("globalGoodOut", 1'b1, globalGood);
    @(posedge mclk);
    fault <= 6'h04;
    for (n = 0; n < 5300 && globalGood === 1'b1; n++) @(negedge mclk);
    chk("deglitch", 1'b1, n >= 4900 && n < 5300);
    chk("globalGoodOut", 1'b0, globalGood);
    bus(1'h1, 8'h04, 32'h4, 32'h0, 32'h0, 1'h0);
    repeat (10) @(negedge mclk);
    chk("globalGoodOut", 1'b1, globalGood);
    @(posedge mclk);
    therm <= 1'b1;
    for (n = 0; n < 5300 && globalGood === 1'b1; n++) @(negedge mclk);
    chk("globalGoodOut", 1'b0, globalGood);
    bus(1'h1, 8'h08, 32'h101, 32'h0, 32'h0, 1'h0);
    @(posedge mclk);
    therm <= 1'b0;
    cePin <= 1'b0;
    repeat (5) @(negedge mclk);
    chk("regulatorEnable", 6'h00, regEn);
    chk("boostDisconnectOut", 1'b0, discon);
    chk("bucketDischargeEn", 5'h01, dischEn);
    chk("boostSinkEn", 1'b0, sinkEn);
    chk("boostSinkCode", 32'h1, sinkCode);
    bus(1'h1, 8'h04, 32'h3F, 32'h0, 32'h0, 1'h1);
    bus(1'h0, 8'h04, 32'h0, fullMask, 32'h4, 1'h0);
    summarize();
  end
endmodule : pss_state_supervisor_test
